/* File: reset_source_controller_bench.sv */
`default_nettype none
// ==========================================================================
// Self-checking bench for the reset source controller
module reset_source_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
  typedef struct {logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] exp;} rsc_row_t;
  logic clk = 0, rstn = 0, por_req = 0, hard_req = 0, por_n, hard_wire;
  logic wdt_zero = 0, bmon_zero = 0, tap = 0, we = 0, re = 0;
  logic [CFG_W-1:0] cfg_pins = 4'ha;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rd_d;
  logic pin_o, oe, wdt_ev, bmon_ev, pll_rst, core_rst, per_rst, wb_rst, csh_rst;
  logic [CFG_W-1:0] cfg_o;
  logic [DATA_W-1:0] rdata;
  int n_fail = 0, check_count = 0, cyc = 0, n_oe, nw, nb;
  rsc_row_t rows [5];
  always #2 clk = ~clk;
  rsc_board_model u_rsc_board_model (.clk_i(clk), .por_req_i(por_req),
    .hard_req_i(hard_req), .dev_oe_i(oe), .power_on_reset_pin_n_o(por_n),
    .hard_wire_o(hard_wire));
  rsc_reset_ctrl u_rsc_reset_ctrl (.clk_i(clk), .rstn_i(rstn),
    .power_on_reset_pin_n_i(por_n), .hard_reset_pin_n_i(hard_wire),
    .hard_reset_pin_n_o(pin_o), .hard_reset_pin_oe_o(oe), .cfg_pins_i(cfg_pins),
    .cfg_o(cfg_o), .wdt_zero_i(wdt_zero), .bmon_zero_i(bmon_zero),
    .tap_boundary_i(tap), .wdt_event_o(wdt_ev), .bmon_event_o(bmon_ev),
    .system_pll_rst_o(pll_rst), .ext_core_rst_o(core_rst), .periph_rst_o(per_rst),
    .wdt_bmon_rst_o(wb_rst), .clock_stop_halt_rst_o(csh_rst), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata));
  // ==========================================================================
  // Bus and wait helpers
  task automatic complete_run();
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; we <= 1'b1; end
    @(posedge clk) we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample right there.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk) begin addr <= a; re <= 1'b1; end
    @(posedge clk) re <= 1'b0;
    #1 d = rdata;
  endtask
  // Waits for the flow to end; counts cycles with the pin pulled by the device.
  task automatic wait_idle(output int n);
    n = 0;
    for (int i = 0; i < 3000 && (core_rst !== 1'b0 || oe !== 1'b0); i++) begin
      @(posedge clk) #1;
      if (oe === 1'b1) n++;
    end
    `CHK(core_rst, 1'b0)
  endtask
  task automatic count_ev(input int len);
    nw = 0;
    nb = 0;
    repeat (len) begin
      @(posedge clk) #1;
      if (wdt_ev === 1'b1) nw++;
      if (bmon_ev === 1'b1) nb++;
    end
  endtask
  // One-cycle request to the board; the board stretches it past the least time.
  task automatic por_pulse();
    @(posedge clk) por_req <= 1'b1;
    @(posedge clk) por_req <= 1'b0;
  endtask
  // Cuts a hang short; the longest flow is a few hundred cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    rows = '{'{REG_CTRL, 32'h3}, '{REG_STATUS, 32'h1}, '{REG_CFG, 32'ha},
             '{REG_STATE, 32'h0}, '{8'h10, 32'h0}};
    // Every reset output is held while the reset pin is low.
    repeat (9) @(posedge clk);
    #1;
    `CHK({pll_rst, oe, pin_o, core_rst, per_rst, wb_rst, csh_rst}, 7'h6f)
    `CHK({cfg_o, rdata, wdt_ev, bmon_ev}, 38'h0)
    @(posedge clk) rstn <= 1'b1;
    repeat (4) @(posedge clk) #1;
    wait_idle(n_oe);
    // Power-on flow reaches every reset output and pulls the pin.
    por_pulse();
    repeat (8) @(posedge clk) #1;
    `CHK(pll_rst, 1'b1)
    `CHK(oe, 1'b1)
    `CHK(pin_o, 1'b0)
    `CHK({core_rst, per_rst, wb_rst, csh_rst}, 4'hf)
    wait_idle(n_oe);
    foreach (rows[i]) begin
      rd(rows[i].addr, rd_d);
      `CHK(rd_d, rows[i].exp)
    end
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS, rd_d);
    `CHK(rd_d, 32'h0)
    // Hard flows from watchdog, bus monitor and the pin; straps must stay frozen.
    @(posedge clk) cfg_pins <= 4'h5;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) begin
        wdt_zero <= (k == 0);
        bmon_zero <= (k == 1);
        hard_req <= (k == 2);
      end
      count_ev(6);
      `CHK({nw, nb}, {32'(k == 0), 32'(k == 1)})
      `CHK({oe, hard_wire, pll_rst, core_rst}, 4'b1001)
      @(posedge clk) begin wdt_zero <= 1'b0; bmon_zero <= 1'b0; hard_req <= 1'b0; end
      wait_idle(n_oe);
      `CHK(n_oe >= 250 && n_oe <= 258, 1'b1)
      `CHK(cfg_o, 4'ha)
      rd(REG_STATUS, rd_d);
      `CHK(rd_d, 32'(k == 0 ? 4 : k == 1 ? 8 : 2))
    end
    // Disabled sources still pulse their events but start no flow.
    wr(REG_CTRL, 32'h0);
    @(posedge clk) begin wdt_zero <= 1'b1; bmon_zero <= 1'b1; end
    count_ev(8);
    `CHK({nw, nb}, {32'd1, 32'd1})
    `CHK({oe, core_rst}, 2'b00)
    @(posedge clk) begin wdt_zero <= 1'b0; bmon_zero <= 1'b0; end
    rd(REG_STATE, rd_d);
    `CHK(rd_d, 32'(ST_IDLE))
    wr(REG_CTRL, 32'h3);
    // Soft flow resets the core but leaves the pin and the PLL alone.
    @(posedge clk) tap <= 1'b1;
    repeat (6) @(posedge clk) #1;
    `CHK({core_rst, per_rst, oe, pll_rst}, 4'b1100)
    @(posedge clk) tap <= 1'b0;
    repeat (4) @(posedge clk) #1;
    wait_idle(n_oe);
    `CHK(n_oe, 0)
    `CHK(cfg_o, 4'ha)
    rd(REG_STATUS, rd_d);
    `CHK(rd_d, 32'h10)
    // A power-on request in mid soft flow takes over with the full flow.
    @(posedge clk) tap <= 1'b1;
    repeat (5) @(posedge clk);
    por_pulse();
    repeat (8) @(posedge clk) #1;
    `CHK({pll_rst, oe}, 2'b11)
    @(posedge clk) tap <= 1'b0;
    wait_idle(n_oe);
    rd(REG_STATUS, rd_d);
    `CHK(rd_d[STS_POR], 1'b1)
    `CHK(cfg_o, 4'h5)
    // A reset in mid-run returns every output to its reset level and reruns power-on.
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk) #1;
    `CHK({pll_rst, oe, core_rst, wdt_ev, bmon_ev}, 5'h1c)
    `CHK({cfg_o, rdata}, 36'h0)
    @(posedge clk) rstn <= 1'b1;
    repeat (4) @(posedge clk) #1;
    wait_idle(n_oe);
    `CHK(n_oe >= int'(POR_HOLD_CYC), 1'b1)
    rd(REG_STATUS, rd_d);
    `CHK(rd_d, 32'h0)
    rd(REG_CFG, rd_d);
    `CHK(rd_d, 32'h5)
    complete_run();
  end
endmodule // reset_source_controller_bench
`default_nettype wire

/* File: rsc_board_model.sv */
`default_nettype none
// ==========================================================================
// Board supervisor and reset circuitry facing the controller's reset pins
module rsc_board_model
  import rsc_pkg::*;
(
  // Clock.
  input  wire logic clk_i,
  // Requests from the bench.
  input  wire logic por_req_i,
  input  wire logic hard_req_i,
  // Device open-drain enable.
  input  wire logic dev_oe_i,
  // Resolved pins.
  output var  logic power_on_reset_pin_n_o,
  output var  logic hard_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned por_cnt;
  initial por_cnt = 0;
  // A request holds the pin low for a few cycles beyond the least time, for margin.
  always @(posedge clk_i) begin
    if (por_req_i) begin
      por_cnt <= POR_MIN_REF_CYC + 4;
    end else if (por_cnt != 0) begin
      por_cnt <= por_cnt - 1;
    end
  end
  // The wire has a pull-up; either party can only pull it low.
  always_comb power_on_reset_pin_n_o = (por_cnt == 0);
  always_comb hard_wire_o = !(dev_oe_i || hard_req_i);
endmodule // rsc_board_model
`default_nettype wire

/* File: rsc_pkg.sv */
`default_nettype none
// ==========================================================================
// Reset source controller shared constants
package rsc_pkg;

  // Clock rate and widths.
  localparam int unsigned CLK_MHZ = 250;
  localparam int          CFG_W   = 4;
  localparam int          ADDR_W  = 8;
  localparam int          DATA_W  = 32;
  localparam int          TMR_W   = 12;
  localparam int          STS_W   = 5;
  localparam int          EN_W    = 2;

  // Least time the board holds the power-on pin, in reference clock cycles.
  localparam int unsigned POR_MIN_REF_CYC = 16;

  // Hold times of the flows, in ns, and the cycle counts derived from them.
  localparam int unsigned POR_HOLD_NS   = 256;
  localparam int unsigned HARD_DRIVE_NS = 1024;
  localparam int unsigned SOFT_HOLD_NS  = 64;
  localparam logic [TMR_W-1:0] POR_HOLD_CYC =
    TMR_W'((POR_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] HARD_DRIVE_CYC =
    TMR_W'((HARD_DRIVE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TMR_W-1:0] SOFT_HOLD_CYC =
    TMR_W'((SOFT_HOLD_NS * CLK_MHZ + 999) / 1000);

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CFG    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATE  = 8'h0c;

  // Control fields and reset value.
  localparam int             CTRL_WDT_EN  = 0;
  localparam int             CTRL_BMON_EN = 1;
  localparam logic [EN_W-1:0] CTRL_RST_VAL = 2'h3;

  // Reset status fields.
  localparam int STS_POR      = 0;
  localparam int STS_HARD_EXT = 1;
  localparam int STS_WDT      = 2;
  localparam int STS_BMON     = 3;
  localparam int STS_TAP      = 4;

  // Flow states.
  typedef enum logic [2:0] {
    ST_IDLE        = 3'b000,
    ST_POR_ASSERT  = 3'b001,
    ST_POR_HOLD    = 3'b010,
    ST_HARD_DRIVE  = 3'b011,
    ST_HARD_WAIT   = 3'b100,
    ST_SOFT_ASSERT = 3'b101,
    ST_SOFT_HOLD   = 3'b110
  } rsc_state_t;

endpackage : rsc_pkg
`default_nettype wire

/* File: rsc_reset_ctrl.sv */
`default_nettype none
module rsc_reset_ctrl (
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // Board reset pins.
  input  wire logic                  power_on_reset_pin_n_i,
  input  wire logic                  hard_reset_pin_n_i,
  output var  logic                  hard_reset_pin_n_o,
  output var  logic                  hard_reset_pin_oe_o,
  // Configuration straps.
  input  wire logic [rsc_pkg::CFG_W-1:0] cfg_pins_i,
  output var  logic [rsc_pkg::CFG_W-1:0] cfg_o,
  // Internal reset sources.
  input  wire logic                  wdt_zero_i,
  input  wire logic                  bmon_zero_i,
  input  wire logic                  tap_boundary_i,
  // Source events.
  output var  logic                  wdt_event_o,
  output var  logic                  bmon_event_o,
  // Reset outputs.
  output var  logic                  system_pll_rst_o,
  output var  logic                  ext_core_rst_o,
  output var  logic                  periph_rst_o,
  output var  logic                  wdt_bmon_rst_o,
  output var  logic                  clock_stop_halt_rst_o,
  // Register port.
  input  wire logic [rsc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [rsc_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                  we_i,
  input  wire logic                  re_i,
  output var  logic [rsc_pkg::DATA_W-1:0] rdata_o
);
  import rsc_pkg::*;

  // ========================================================================
  // State
  typedef struct packed {
    rsc_state_t        st;
    logic              por_m;
    logic              por_s;
    logic              hrst_m;
    logic              hrst_s;
    logic              tap_m;
    logic              tap_s;
    logic [CFG_W-1:0]  cfg_m;
    logic [CFG_W-1:0]  cfg_s;
    logic [CFG_W-1:0]  cfg;
    logic              wdt_prev;
    logic              bmon_prev;
    logic              wdt_ev;
    logic              bmon_ev;
    logic [EN_W-1:0]   en;
    logic [STS_W-1:0]  sts;
    logic [DATA_W-1:0] rdata;
    logic              pll_rst;
    logic              sys_rst;
    logic              drive;
  } rsc_ctrl_state_t;

  localparam rsc_ctrl_state_t RST_STATE = '{
    st: ST_POR_ASSERT, por_m: 1'b0, por_s: 1'b0, hrst_m: 1'b1, hrst_s: 1'b1,
    tap_m: 1'b0, tap_s: 1'b0, cfg_m: '0, cfg_s: '0, cfg: '0,
    wdt_prev: 1'b0, bmon_prev: 1'b0, wdt_ev: 1'b0, bmon_ev: 1'b0,
    en: CTRL_RST_VAL, sts: '0, rdata: '0,
    pll_rst: 1'b1, sys_rst: 1'b1, drive: 1'b1};

  rsc_ctrl_state_t q, d;
  logic [1:0]      rst_sync_q;
  logic            rst_n;
  logic            wdt_now;
  logic            bmon_now;
  logic            hard_cause;
  logic            start;
  logic [STS_W-1:0] cause;
  logic [STS_W-1:0] clr;

  rsc_tmr_if tmr_if ();

  // ========================================================================
  // Reset release
  // Assertion is immediate, release is delayed two edges to avoid metastability.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ========================================================================
  // Hold timer
  rsc_timer u_timer (
    .clk_i  (clk_i),
    .rst_ni (rst_n),
    .tmr    (tmr_if.tmr)
  );

  // ========================================================================
  // Next state
  always_comb begin
    d = q;
    tmr_if.load  = 1'b0;
    tmr_if.count = '0;
    start = 1'b0;
    cause = '0;
    clr   = '0;
    d.rdata = '0;

    // Pins pass two flops; only the second stage is read by the logic.
    d.por_m  = power_on_reset_pin_n_i;
    d.por_s  = q.por_m;
    d.hrst_m = hard_reset_pin_n_i;
    d.hrst_s = q.hrst_m;
    d.tap_m  = tap_boundary_i;
    d.tap_s  = q.tap_m;
    d.cfg_m  = cfg_pins_i;
    d.cfg_s  = q.cfg_m;

    // Counts reaching zero are taken on the rising edge of the zero flag.
    wdt_now     = wdt_zero_i & ~q.wdt_prev;
    bmon_now    = bmon_zero_i & ~q.bmon_prev;
    d.wdt_prev  = wdt_zero_i;
    d.bmon_prev = bmon_zero_i;
    d.wdt_ev    = wdt_now;
    d.bmon_ev   = bmon_now;

    // Hard reset sources: the pin, or an enabled watchdog or monitor event.
    cause[STS_HARD_EXT] = ~q.hrst_s;
    cause[STS_WDT]      = wdt_now & q.en[CTRL_WDT_EN];
    cause[STS_BMON]     = bmon_now & q.en[CTRL_BMON_EN];
    hard_cause = |cause;
    cause[STS_TAP] = q.tap_s & ~hard_cause;

    // Register writes.
    if (we_i) begin
      unique case (addr_i)
        REG_CTRL:   d.en = wdata_i[EN_W-1:0];
        REG_STATUS: clr = wdata_i[STS_W-1:0];
        default:    ;
      endcase
    end

    // Register reads; unmapped offsets read zero.
    if (re_i) begin
      unique case (addr_i)
        REG_CTRL:   d.rdata = DATA_W'(q.en);
        REG_STATUS: d.rdata = DATA_W'(q.sts);
        REG_CFG:    d.rdata = DATA_W'(q.cfg);
        REG_STATE:  d.rdata = DATA_W'(q.st);
        default:    d.rdata = '0;
      endcase
    end

    unique case (q.st)
      ST_IDLE: begin
        if (hard_cause) begin
          d.st  = ST_HARD_DRIVE;
          start = 1'b1;
        end else if (q.tap_s) begin
          d.st  = ST_SOFT_ASSERT;
          start = 1'b1;
        end
      end
      ST_POR_ASSERT: begin
        // Straps are followed for as long as the pin is held.
        d.cfg = q.cfg_s;
        // The board keeps the pin low long enough for the PLL; we just follow it.
        if (q.por_s) begin
          d.st = ST_POR_HOLD;
          tmr_if.load  = 1'b1;
          tmr_if.count = POR_HOLD_CYC;
        end
      end
      ST_POR_HOLD: begin
        if (tmr_if.expired) begin
          d.st = ST_HARD_WAIT;
        end
      end
      ST_HARD_DRIVE: begin
        if (tmr_if.expired) begin
          d.st = ST_HARD_WAIT;
        end
      end
      ST_HARD_WAIT: begin
        // The board may keep the pin low after we let go.
        if (q.hrst_s) begin
          d.st = ST_IDLE;
        end
      end
      ST_SOFT_ASSERT, ST_SOFT_HOLD: begin
        // A hard cause escalates a soft flow, since it covers more.
        if (hard_cause) begin
          d.st  = ST_HARD_DRIVE;
          start = 1'b1;
        end else if (q.tap_s) begin
          d.st = ST_SOFT_ASSERT;
        end else if (q.st == ST_SOFT_ASSERT) begin
          d.st = ST_SOFT_HOLD;
          tmr_if.load  = 1'b1;
          tmr_if.count = SOFT_HOLD_CYC;
        end else if (tmr_if.expired) begin
          d.st = ST_IDLE;
        end
      end
      // The one unused code falls back to the widest flow rather than stall.
      default: begin
        d.st = ST_POR_ASSERT;
      end
    endcase

    // The power-on pin overrides any flow in progress.
    if (!q.por_s && q.st != ST_POR_ASSERT) begin
      d.st  = ST_POR_ASSERT;
      start = 1'b1;
      cause = '0;
      cause[STS_POR] = 1'b1;
    end

    // Timer load for a fresh hard flow.
    if (start && d.st == ST_HARD_DRIVE) begin
      tmr_if.load  = 1'b1;
      tmr_if.count = HARD_DRIVE_CYC;
    end

    // A new flow replaces the record, so a clear in that cycle cannot lose it.
    if (start) begin
      d.sts = cause;
    end else begin
      d.sts = q.sts & ~clr;
    end

    // Reset outputs are registered copies of the next state.
    d.pll_rst = (d.st == ST_POR_ASSERT) || (d.st == ST_POR_HOLD);
    d.sys_rst = (d.st != ST_IDLE);
    d.drive   = (d.st == ST_POR_ASSERT) || (d.st == ST_POR_HOLD) ||
                (d.st == ST_HARD_DRIVE);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs
  // The pin is only ever pulled low; high comes from the board pull-up.
  assign hard_reset_pin_n_o    = 1'b0;
  assign hard_reset_pin_oe_o   = q.drive;
  assign cfg_o                 = q.cfg;
  assign wdt_event_o           = q.wdt_ev;
  assign bmon_event_o          = q.bmon_ev;
  assign system_pll_rst_o      = q.pll_rst;
  assign ext_core_rst_o        = q.sys_rst;
  assign periph_rst_o          = q.sys_rst;
  assign wdt_bmon_rst_o        = q.sys_rst;
  assign clock_stop_halt_rst_o = q.sys_rst;
  assign rdata_o               = q.rdata;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_por_starts_flow: assert property (
    (!q.por_s && q.st != ST_POR_ASSERT) |=> (q.st == ST_POR_ASSERT) ##1
      (system_pll_rst_o && hard_reset_pin_oe_o && ext_core_rst_o))
    else $error("power-on pin did not start the power-on flow");

  a_cfg_kept_still: assert property (
    (q.st != ST_POR_ASSERT) |=> $stable(cfg_o))
    else $error("configuration changed outside power-on reset");

  a_pll_por_only: assert property (
    system_pll_rst_o |-> (q.st == ST_POR_ASSERT || q.st == ST_POR_HOLD))
    else $error("PLL reset outside the power-on flow");

  a_pin_low_only: assert property (
    $rose(hard_reset_pin_oe_o) |-> (!hard_reset_pin_n_o && hard_reset_pin_oe_o)[*8])
    else $error("hard pin driven high or released too soon");

  a_hard_drives_pin: assert property (
    (q.st == ST_HARD_DRIVE) |-> (hard_reset_pin_oe_o && ext_core_rst_o))
    else $error("hard flow without pin drive or core reset");

  a_wdt_event_hard: assert property (
    (q.st == ST_IDLE && q.por_s && $rose(wdt_zero_i) && q.en[CTRL_WDT_EN])
      |=> wdt_event_o && q.st == ST_HARD_DRIVE ##1 hard_reset_pin_oe_o)
    else $error("enabled watchdog event did not start hard reset");

  a_bmon_event_hard: assert property (
    (q.st == ST_IDLE && q.por_s && $rose(bmon_zero_i) && q.en[CTRL_BMON_EN])
      |=> bmon_event_o && q.st == ST_HARD_DRIVE ##1 hard_reset_pin_oe_o)
    else $error("enabled bus monitor event did not start hard reset");

  a_soft_no_pin: assert property (
    (q.st == ST_SOFT_ASSERT || q.st == ST_SOFT_HOLD)
      |-> (!hard_reset_pin_oe_o && periph_rst_o && !system_pll_rst_o))
    else $error("soft flow touched the hard pin or PLL");

  a_all_flows_reset: assert property (
    (q.st != ST_IDLE) |-> (wdt_bmon_rst_o && clock_stop_halt_rst_o &&
      ext_core_rst_o && periph_rst_o))
    else $error("a flow left a block out of reset");

  a_status_records: assert property (
    start |=> (q.sts == $past(cause)))
    else $error("reset status does not match the cause");

  a_por_abandons: assert property (
    (!q.por_s && q.st inside {ST_HARD_DRIVE, ST_HARD_WAIT, ST_SOFT_ASSERT,
      ST_SOFT_HOLD}) |=> (q.st == ST_POR_ASSERT && q.sts[STS_POR]))
    else $error("power-on did not abandon a running flow");

  // A zero flag that stays high must not repeat its event every cycle.
  a_wdt_single_pulse: assert property (
    wdt_event_o |=> !wdt_event_o)
    else $error("watchdog event lasted more than one cycle");

  a_bmon_single_pulse: assert property (
    bmon_event_o |=> !bmon_event_o)
    else $error("bus monitor event lasted more than one cycle");

  c_por_flow:  cover property ((q.st == ST_POR_HOLD) ##1 (q.st == ST_HARD_WAIT));
  c_wdt_hard:  cover property (wdt_event_o && q.st == ST_HARD_DRIVE);
  c_ext_hard:  cover property ((q.st == ST_IDLE) ##1 q.sts[STS_HARD_EXT]);
  c_tap_soft:  cover property ((q.st == ST_SOFT_HOLD) ##1 (q.st == ST_IDLE));
  c_bmon_hard: cover property (bmon_event_o && q.st == ST_HARD_DRIVE);

endmodule : rsc_reset_ctrl
`default_nettype wire

/* File: rsc_timer.sv */
`default_nettype none
// ==========================================================================
// Down-counter that times each hold phase
module rsc_timer (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_ni,
  // Load and expiry.
  rsc_tmr_if.tmr    tmr
);
  import rsc_pkg::*;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } rsc_tmr_state_t;

  rsc_tmr_state_t q, d;

  // A load wins over counting so a phase always gets its full length.
  always_comb begin
    d = q;
    if (tmr.load) begin
      d.cnt = tmr.count;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - TMR_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Expiry is decoded from the count register.
  assign tmr.expired = (q.cnt == '0);

endmodule : rsc_timer
`default_nettype wire

/* File: rsc_tmr_if.sv */
`default_nettype none
// ==========================================================================
// Hold timer link between the flow machine and its down-counter
interface rsc_tmr_if;
  import rsc_pkg::*;
  logic             load;
  logic [TMR_W-1:0] count;
  logic             expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface : rsc_tmr_if
`default_nettype wire
